/* verilog/quad_angle_regs.vh */
// Constants shared by the angle encoder: register map, settings tables and timing.
`ifndef QUAD_ANGLE_REGS_VH
`define QUAD_ANGLE_REGS_VH

// Register byte offsets on the plain register port.
`define ADDR_CTRL        8'h00
`define ADDR_ANGLE       8'h04
`define ADDR_POSITION    8'h08
`define ADDR_STATUS      8'h0C

// Control register fields and reset value.
`define CTRL_RES_LSB     0
`define CTRL_RES_MSB     4
`define CTRL_HYST_LSB    5
`define CTRL_HYST_MSB    7
`define CTRL_DIR_BIT     8
`define CTRL_WIDTH       9
`define CTRL_RESET       9'h002

// Status register fields.
`define STAT_PENDING_BIT 0
`define STAT_BUSY_BIT    1

// Clock rate and unit scale for turning nanoseconds into cycles.
`define CLK_MHZ          25
`define NS_PER_US        1000

// Angle word: one full turn spans 2^16 codes; half a turn is the pre-rotation offset.
`define ANGLE_HALF_TURN  16'h8000

// Resolution table: counts per turn (binary 0..8, decimal 9..20).
`define RES_CNT_0  14'h2000
`define RES_CNT_1  14'h1000
`define RES_CNT_2  14'h0800
`define RES_CNT_3  14'h0400
`define RES_CNT_4  14'h0200
`define RES_CNT_5  14'h0100
`define RES_CNT_6  14'h0080
`define RES_CNT_7  14'h0040
`define RES_CNT_8  14'h0020
`define RES_CNT_9  14'h07D0
`define RES_CNT_10 14'h0640
`define RES_CNT_11 14'h03E8
`define RES_CNT_12 14'h0320
`define RES_CNT_13 14'h01F4
`define RES_CNT_14 14'h0190
`define RES_CNT_15 14'h0140
`define RES_CNT_16 14'h00C8
`define RES_CNT_17 14'h00A0
`define RES_CNT_18 14'h0064
`define RES_CNT_19 14'h0050
`define RES_CNT_20 14'h0028

// Least transition spacing per resolution, in nanoseconds.
`define TD_NS_0  16'h007A
`define TD_NS_1  16'h0092
`define TD_NS_2  16'h0125
`define TD_NS_3  16'h0249
`define TD_NS_4  16'h0492
`define TD_NS_5  16'h0924
`define TD_NS_6  16'h1248
`define TD_NS_7  16'h2490
`define TD_NS_8  16'h4970
`define TD_NS_9  16'h0125
`define TD_NS_10 16'h0186
`define TD_NS_11 16'h0249
`define TD_NS_12 16'h030C
`define TD_NS_13 16'h04EC
`define TD_NS_14 16'h0618
`define TD_NS_15 16'h079E
`define TD_NS_16 16'h0C30
`define TD_NS_17 16'h0F3C
`define TD_NS_18 16'h1860
`define TD_NS_19 16'h1E78
`define TD_NS_20 16'h3CF0

// Hysteresis in angle codes (0, 360/4096 ... 360/256 degrees).
`define HYST_0 16'h0000
`define HYST_1 16'h0010
`define HYST_2 16'h0020
`define HYST_3 16'h0040
`define HYST_4 16'h0080
`define HYST_5 16'h0100

`endif

/* verilog/atan_cordic.v */
// Iterative CORDIC that turns a sine/cosine sample pair into an angle word.
`timescale 1ns/1ps
`include "quad_angle_regs.vh"
module atan_cordic #(
  parameter SAMPLE_W = 12,
  parameter ITER     = 14
) (
  input  wire                clock,
  input  wire                rstn,
  input  wire                start,
  input  wire [SAMPLE_W-1:0] sinIn,
  input  wire [SAMPLE_W-1:0] cosIn,
  output reg  [15:0]         angle_q,
  output reg                 done_q,
  output wire                busy
);
  localparam XW = SAMPLE_W + 2;

  reg  [XW-1:0] x_q;      // Rotated cosine term, grows by the CORDIC gain.
  reg  [XW-1:0] y_q;      // Rotated sine term, driven toward zero.
  reg  [15:0]   z_q;      // Accumulated angle.
  reg  [3:0]    step_q;   // Current iteration.
  reg           run_q;    // Iterations in progress.
  wire [XW-1:0] xSh;
  wire [XW-1:0] ySh;
  wire [XW-1:0] sinExt;
  wire [XW-1:0] cosExt;

  assign busy   = run_q;
  assign xSh    = $signed(x_q) >>> step_q;
  assign ySh    = $signed(y_q) >>> step_q;
  assign sinExt = {{2{sinIn[SAMPLE_W-1]}}, sinIn};
  assign cosExt = {{2{cosIn[SAMPLE_W-1]}}, cosIn};

  // Arctangent of 2^-i in angle codes; only the ratio of the inputs matters.
  function [15:0] atanStep;
    input [3:0] i;
    begin
      case (i)
        4'h0:    atanStep = 16'h2000;
        4'h1:    atanStep = 16'h12E4;
        4'h2:    atanStep = 16'h09FB;
        4'h3:    atanStep = 16'h0511;
        4'h4:    atanStep = 16'h028B;
        4'h5:    atanStep = 16'h0146;
        4'h6:    atanStep = 16'h00A3;
        4'h7:    atanStep = 16'h0051;
        4'h8:    atanStep = 16'h0029;
        4'h9:    atanStep = 16'h0014;
        4'hA:    atanStep = 16'h000A;
        4'hB:    atanStep = 16'h0005;
        4'hC:    atanStep = 16'h0003;
        default: atanStep = 16'h0001;
      endcase
    end
  endfunction

  // Vectoring mode: the left half plane is folded over first so the
  // iterations always converge, then y is rotated to zero.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      x_q     <= {XW{1'b0}};
      y_q     <= {XW{1'b0}};
      z_q     <= 16'h0000;
      step_q  <= 4'h0;
      run_q   <= 1'b0;
      angle_q <= 16'h0000;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!run_q) begin
        if (start) begin
          // Folding keeps the angle at zero for a positive cosine and zero sine.
          if (cosExt[XW-1]) begin
            x_q <= -cosExt;
            y_q <= -sinExt;
            z_q <= `ANGLE_HALF_TURN;
          end else begin
            x_q <= cosExt;
            y_q <= sinExt;
            z_q <= 16'h0000;
          end
          step_q <= 4'h0;
          run_q  <= 1'b1;
        end
      end else begin
        if (!y_q[XW-1]) begin
          x_q <= x_q + ySh;
          y_q <= y_q - xSh;
          z_q <= z_q + atanStep(step_q);
        end else begin
          x_q <= x_q - ySh;
          y_q <= y_q + xSh;
          z_q <= z_q - atanStep(step_q);
        end
        if (step_q == ITER - 1) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
          angle_q <= (!y_q[XW-1]) ? z_q + atanStep(step_q) : z_q - atanStep(step_q);
        end else begin
          step_q <= step_q + 4'h1;
        end
      end
    end
  end
endmodule

/* verilog/quadrature_angle_encoder.v */
// Angle interpolator with A/B quadrature, reference mark and absolute position outputs.
`timescale 1ns/1ps
`include "quad_angle_regs.vh"
// What this block does
// - Settings pick resolution, hysteresis and counting direction.
// - Angle comes from arctangent of sine over cosine.
// - Absolute and incremental outputs run together.
// - Transitions spaced by resolution-dependent minimum time.
// - Two quadrature outputs; one toggles per step.
// - Reference pulse one count wide, edge aligned.
// - Reference pulse sits at zero angle.
// - Positive direction, clockwise: second output leads.
// - Negative direction inverts the count sense.
// - Reference output only while enable input high.
module quadrature_angle_encoder #(
  parameter SAMPLE_W = 12,
  parameter ITER     = 14,
  parameter CNT_W    = 14
) (
  input  wire                clock,
  input  wire                rstn,
  input  wire [SAMPLE_W-1:0] sinSample,
  input  wire [SAMPLE_W-1:0] cosSample,
  input  wire                sampleValid,
  input  wire                marker_enable_in,
  input  wire [7:0]          regAddr,
  input  wire [31:0]         regWdata,
  input  wire                regWrite,
  input  wire                regRead,
  output reg  [31:0]         regRdata_q,
  output reg                 quadA_q,
  output reg                 quadB_q,
  output reg                 reference_mark_out_q,
  output reg  [CNT_W-1:0]    absPosition_q
);
  // Software settings.
  reg  [`CTRL_WIDTH-1:0] ctrl_q;
  wire [4:0]             resSel  = ctrl_q[`CTRL_RES_MSB:`CTRL_RES_LSB];
  wire [2:0]             hystSel = ctrl_q[`CTRL_HYST_MSB:`CTRL_HYST_LSB];
  wire                   dirNeg  = ctrl_q[`CTRL_DIR_BIT];

  // Angle path state.
  wire [15:0]      rawAngle;      // Arctangent result for the latest sample.
  wire             angleDone;     // One-cycle strobe when rawAngle is new.
  wire             cordicBusy;    // Samples arriving while busy are dropped.
  reg  [15:0]      filtAngle_q;   // Angle after hysteresis.
  reg              seeded_q;      // First angle loads without hysteresis.
  reg  [CNT_W-1:0] cnt_q;         // Position currently shown on A/B.
  reg  [9:0]       gap_q;         // Cycles left before the next step is allowed.

  // Counts per turn for a resolution code; unused codes fall back to the finest.
  function [CNT_W-1:0] resCount;
    input [4:0] sel;
    begin
      case (sel)
        5'h01:   resCount = `RES_CNT_1;
        5'h02:   resCount = `RES_CNT_2;
        5'h03:   resCount = `RES_CNT_3;
        5'h04:   resCount = `RES_CNT_4;
        5'h05:   resCount = `RES_CNT_5;
        5'h06:   resCount = `RES_CNT_6;
        5'h07:   resCount = `RES_CNT_7;
        5'h08:   resCount = `RES_CNT_8;
        5'h09:   resCount = `RES_CNT_9;
        5'h0A:   resCount = `RES_CNT_10;
        5'h0B:   resCount = `RES_CNT_11;
        5'h0C:   resCount = `RES_CNT_12;
        5'h0D:   resCount = `RES_CNT_13;
        5'h0E:   resCount = `RES_CNT_14;
        5'h0F:   resCount = `RES_CNT_15;
        5'h10:   resCount = `RES_CNT_16;
        5'h11:   resCount = `RES_CNT_17;
        5'h12:   resCount = `RES_CNT_18;
        5'h13:   resCount = `RES_CNT_19;
        5'h14:   resCount = `RES_CNT_20;
        default: resCount = `RES_CNT_0;
      endcase
    end
  endfunction

  // Least spacing in nanoseconds for a resolution code.
  function [15:0] tdNs;
    input [4:0] sel;
    begin
      case (sel)
        5'h01:   tdNs = `TD_NS_1;
        5'h02:   tdNs = `TD_NS_2;
        5'h03:   tdNs = `TD_NS_3;
        5'h04:   tdNs = `TD_NS_4;
        5'h05:   tdNs = `TD_NS_5;
        5'h06:   tdNs = `TD_NS_6;
        5'h07:   tdNs = `TD_NS_7;
        5'h08:   tdNs = `TD_NS_8;
        5'h09:   tdNs = `TD_NS_9;
        5'h0A:   tdNs = `TD_NS_10;
        5'h0B:   tdNs = `TD_NS_11;
        5'h0C:   tdNs = `TD_NS_12;
        5'h0D:   tdNs = `TD_NS_13;
        5'h0E:   tdNs = `TD_NS_14;
        5'h0F:   tdNs = `TD_NS_15;
        5'h10:   tdNs = `TD_NS_16;
        5'h11:   tdNs = `TD_NS_17;
        5'h12:   tdNs = `TD_NS_18;
        5'h13:   tdNs = `TD_NS_19;
        5'h14:   tdNs = `TD_NS_20;
        default: tdNs = `TD_NS_0;
      endcase
    end
  endfunction

  // Hysteresis band in angle codes; codes above the largest band saturate.
  function [15:0] hystCodes;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    hystCodes = `HYST_0;
        3'h1:    hystCodes = `HYST_1;
        3'h2:    hystCodes = `HYST_2;
        3'h3:    hystCodes = `HYST_3;
        3'h4:    hystCodes = `HYST_4;
        default: hystCodes = `HYST_5;
      endcase
    end
  endfunction

  wire [CNT_W-1:0] resN = resCount(resSel);
  // A least time rounds up to whole cycles, so the spacing is never shorter.
  wire [31:0]      tdCyc32 = (tdNs(resSel) * `CLK_MHZ + `NS_PER_US - 1) / `NS_PER_US;
  wire [9:0]       tdCycles = tdCyc32[9:0];
  wire [15:0]      hyst = hystCodes(hystSel);

  // The arctangent of the sample ratio makes the angle independent of amplitude.
  atan_cordic #(
    .SAMPLE_W (SAMPLE_W),
    .ITER     (ITER)
  ) uAtan (
    .clock    (clock),
    .rstn     (rstn),
    .start    (sampleValid),
    .sinIn    (sinSample),
    .cosIn    (cosSample),
    .angle_q  (rawAngle),
    .done_q   (angleDone),
    .busy     (cordicBusy)
  );

  // Negative direction mirrors the angle about zero, so zero stays put.
  wire [15:0] dirAngle  = dirNeg ? (16'h0000 - rawAngle) : rawAngle;
  wire [15:0] angleDiff = dirAngle - filtAngle_q;
  wire [16:0] diffS     = {angleDiff[15], angleDiff};
  wire [16:0] hystS     = {1'b0, hyst};

  // Hysteresis: the filtered angle only follows once the new angle leaves the
  // band, then trails it by the band width so noise cannot flip direction.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      filtAngle_q <= 16'h0000;
      seeded_q    <= 1'b0;
    end else if (angleDone) begin
      seeded_q <= 1'b1;
      if (!seeded_q) begin
        filtAngle_q <= dirAngle;
      end else if ($signed(diffS) > $signed(hystS)) begin
        filtAngle_q <= dirAngle - hyst;
      end else if ($signed(diffS) < -$signed(hystS)) begin
        filtAngle_q <= dirAngle + hyst;
      end
    end
  end

  // Scale the angle word to the selected count; works for binary and decimal alike.
  wire [29:0]      scaled = filtAngle_q * resN;
  wire [CNT_W-1:0] target = scaled[29:16];

  // Shortest way round the circle from the shown count to the target.
  wire [CNT_W-1:0] fwdDist = (target >= cnt_q) ? (target - cnt_q) : (target + resN - cnt_q);
  wire             pending = (fwdDist != {CNT_W{1'b0}});
  wire             goUp    = (fwdDist <= (resN >> 1));
  wire             stepNow = pending && (gap_q == 10'h000) && seeded_q;
  wire             outOfRange = (cnt_q >= resN);

  // Step generator: one count per allowed slot, so a backlog drains at the
  // least spacing and the external counter never sees a missed state.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= {CNT_W{1'b0}};
      gap_q <= 10'h000;
    end else begin
      if (gap_q != 10'h000) begin
        gap_q <= gap_q - 10'h001;
      end
      if (outOfRange) begin
        // A resolution change can leave the count past the end of the turn.
        cnt_q <= {CNT_W{1'b0}};
      end else if (stepNow) begin
        gap_q <= tdCycles - 10'h001;
        if (goUp) begin
          cnt_q <= (cnt_q == resN - 1'b1) ? {CNT_W{1'b0}} : cnt_q + 1'b1;
        end else begin
          cnt_q <= (cnt_q == {CNT_W{1'b0}}) ? resN - 1'b1 : cnt_q - 1'b1;
        end
      end
    end
  end

  // Gray mapping of the two low count bits: 00, 01, 11, 10 for (A, B). Up
  // counting raises B a quarter period before A, so B leads on clockwise.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      quadA_q              <= 1'b0;
      quadB_q              <= 1'b0;
      reference_mark_out_q <= 1'b0;
      absPosition_q        <= {CNT_W{1'b0}};
    end else begin
      quadA_q <= cnt_q[1];
      quadB_q <= cnt_q[1] ^ cnt_q[0];
      // The mark spans count zero only: a quarter period, changing with A/B.
      reference_mark_out_q <= marker_enable_in && (cnt_q == {CNT_W{1'b0}});
      // Absolute value tracks the same count as the quadrature lines.
      absPosition_q <= cnt_q;
    end
  end

  // Register writes: only the control register is writable.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (regWrite && (regAddr == `ADDR_CTRL)) begin
      ctrl_q <= regWdata[`CTRL_WIDTH-1:0];
    end
  end

  // Register reads: data stand one cycle after the strobe; unmapped reads give zero.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regRdata_q <= 32'h0000_0000;
    end else if (regRead) begin
      if (regAddr == `ADDR_CTRL) begin
        regRdata_q <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
      end else if (regAddr == `ADDR_ANGLE) begin
        regRdata_q <= {16'h0000, filtAngle_q};
      end else if (regAddr == `ADDR_POSITION) begin
        regRdata_q <= {{(32-CNT_W){1'b0}}, cnt_q};
      end else if (regAddr == `ADDR_STATUS) begin
        regRdata_q <= {30'h0000_0000, cordicBusy, pending};
      end else begin
        regRdata_q <= 32'h0000_0000;
      end
    end else begin
      regRdata_q <= 32'h0000_0000;
    end
  end
endmodule

/* sim/quadrature_angle_encoder_sva.sv */
// Port-level assertions for the angle encoder, attached to the top module by bind.
`timescale 1ns/1ps
`include "quad_angle_regs.vh"
module quadrature_angle_encoder_sva #(
  parameter SAMPLE_W = 12,
  parameter ITER     = 14,
  parameter CNT_W    = 14
) (
  input wire                clock,
  input wire                rstn,
  input wire [SAMPLE_W-1:0] sinSample,
  input wire [SAMPLE_W-1:0] cosSample,
  input wire                sampleValid,
  input wire                marker_enable_in,
  input wire [7:0]          regAddr,
  input wire [31:0]         regWdata,
  input wire                regWrite,
  input wire                regRead,
  input wire [31:0]         regRdata_q,
  input wire                quadA_q,
  input wire                quadB_q,
  input wire                reference_mark_out_q,
  input wire [CNT_W-1:0]    absPosition_q
);
  // Everything here lives in the single system clock domain.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_ONE_TOGGLE: assert property (!($changed(quadA_q) && $changed(quadB_q)))
    else $error("both quadrature outputs moved in one cycle");
  // Four cycles is the finest spacing any resolution allows, so three quiet cycles must follow a step.
  AST_MIN_GAP: assert property ($changed({quadA_q, quadB_q}) |=> $stable({quadA_q, quadB_q}) [*3])
    else $error("quadrature steps closer than four cycles");
  AST_A_PHASE: assert property (quadA_q == absPosition_q[1])
    else $error("output A does not match the count");
  AST_B_PHASE: assert property (quadB_q == (absPosition_q[1] ^ absPosition_q[0]))
    else $error("output B does not match the count");
  // The mark register only starts to follow the count one edge after reset is released.
  AST_MARK_ZERO: assert property ($past(rstn) |->
                                  reference_mark_out_q == ((absPosition_q == 0) && $past(marker_enable_in)))
    else $error("reference mark not tied to count zero");
  AST_MARK_OFF: assert property (!marker_enable_in |=> !reference_mark_out_q)
    else $error("reference mark while disabled");
  AST_POS_READ: assert property ((regRead && regAddr == `ADDR_POSITION) |=>
                                 regRdata_q == {{(32-CNT_W){1'b0}}, absPosition_q})
    else $error("position register differs from absolute output");
  AST_STEP_TOGETHER: assert property ($changed(absPosition_q) |-> $changed({quadA_q, quadB_q}))
    else $error("absolute value moved without a quadrature step");
endmodule

bind quadrature_angle_encoder quadrature_angle_encoder_sva #(
  .SAMPLE_W(SAMPLE_W), .ITER(ITER), .CNT_W(CNT_W)
) quadrature_angle_encoder_sva_i (
  .clock(clock), .rstn(rstn), .sinSample(sinSample), .cosSample(cosSample),
  .sampleValid(sampleValid), .marker_enable_in(marker_enable_in), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata_q(regRdata_q),
  .quadA_q(quadA_q), .quadB_q(quadB_q), .reference_mark_out_q(reference_mark_out_q),
  .absPosition_q(absPosition_q)
);

/* sim/quad_counter_model.sv */
// Behavioural up/down quadrature counter standing at the far side of the incremental outputs.
`timescale 1ns/1ps
module quad_counter_model (
  input  wire    clock,
  input  wire    rstn,
  input  wire    quadA,
  input  wire    quadB,
  input  wire    mark,
  input  wire    clearStats,
  output integer netCount,
  output integer minGap,
  output integer badSteps,
  output integer markCount
);
  wire [1:0] phaseIdx = {quadA, quadA ^ quadB}; // Gray state turned into a 0..3 index.
  reg  [1:0] lastIdx;                           // Index seen at the previous sample.
  reg        lastMark;                          // Mark level at the previous sample.
  integer    gap;                               // Cycles since the last step.

  // Samples every system clock, far faster than the finest step spacing, so no step is lost.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      netCount  <= 0;
      minGap    <= 1000000;
      badSteps  <= 0;
      markCount <= 0;
      lastIdx   <= 2'b00;
      lastMark  <= 1'b0;
      gap       <= 0;
    end else begin
      gap      <= gap + 1;
      lastIdx  <= phaseIdx;
      lastMark <= mark;
      if (clearStats) begin
        minGap <= 1000000;
      end
      if (phaseIdx != lastIdx) begin
        // A jump of two states means both lines moved together and the direction is lost.
        if (phaseIdx == lastIdx + 2'd1) begin
          netCount <= netCount + 1;
        end else if (phaseIdx == lastIdx - 2'd1) begin
          netCount <= netCount - 1;
        end else begin
          badSteps <= badSteps + 1;
        end
        // A cleared figure takes the first gap of the new move as its least one.
        if (clearStats || (gap + 1 < minGap)) begin
          minGap <= gap + 1;
        end
        gap <= 0;
      end
      if (mark && !lastMark) begin
        markCount <= (clearStats ? 0 : markCount) + 1;
      end else if (clearStats) begin
        markCount <= 0;
      end
    end
  end
endmodule

/* sim/quadrature_angle_encoder_test.sv */
// Self-checking bench for the angle encoder: register accesses, angle moves and quadrature counting.
`timescale 1ns/1ps
`include "quad_angle_regs.vh"
module quadrature_angle_encoder_test;
  reg         clock;         // 25 MHz system clock.
  reg         rstn;          // Active-low reset.
  reg  [11:0] sinSample;     // Sine sample.
  reg  [11:0] cosSample;     // Cosine sample.
  reg         sampleValid;   // Conversion request pulse.
  reg         markEnable;    // Reference mark enable level.
  reg  [7:0]  regAddr;       // Register byte address.
  reg  [31:0] regWdata;      // Register write data.
  reg         regWrite;      // Write strobe.
  reg         regRead;       // Read strobe.
  reg         clearStats;    // Restarts the counter model's per-move figures.
  wire [31:0] regRdata_q;
  wire        quadA_q;
  wire        quadB_q;
  wire        reference_mark_out_q;
  wire [13:0] absPosition_q;
  integer     netCount;
  integer     minGap;
  integer     badSteps;
  integer     markCount;
  integer     failures;
  integer     num_checks;

  quadrature_angle_encoder quadrature_angle_encoder_i (
    .clock(clock), .rstn(rstn), .sinSample(sinSample), .cosSample(cosSample),
    .sampleValid(sampleValid), .marker_enable_in(markEnable), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata_q(regRdata_q),
    .quadA_q(quadA_q), .quadB_q(quadB_q), .reference_mark_out_q(reference_mark_out_q),
    .absPosition_q(absPosition_q));
  quad_counter_model quad_counter_model_i (
    .clock(clock), .rstn(rstn), .quadA(quadA_q), .quadB(quadB_q), .mark(reference_mark_out_q),
    .clearStats(clearStats), .netCount(netCount), .minGap(minGap), .badSteps(badSteps),
    .markCount(markCount));

  // Half period of 20 ns gives the 40 ns clock.
  always #20 clock = ~clock;

  // Prints the verdict and ends the run; both the tests and the watchdog end here.
  task wrap_up;
    begin
      if (failures == 0 && num_checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task regWr(input [7:0] addr, input [31:0] data);
    begin
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr  <= addr;
      regWdata <= data;
      @(posedge clock);
      regWrite <= 1'b0;
    end
  endtask

  // Read data stand only in the cycle after the strobe, so they are looked at mid-cycle there.
  task regRd(input [7:0] addr, input [31:0] exp);
    begin
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= addr;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      check(regRdata_q, exp);
    end
  endtask

  // Feeds one sample pair, waits for the count to settle and compares count, register and counter model.
  task automatic move(input [11:0] s, input [11:0] c, input integer expPos, input integer oldPos,
                      input integer n, input integer expGap);
    integer oldNet;
    integer k;
    begin
      oldNet = netCount;
      @(posedge clock);
      sampleValid <= 1'b1;
      clearStats  <= 1'b1;
      sinSample   <= s;
      cosSample   <= c;
      @(posedge clock);
      sampleValid <= 1'b0;
      clearStats  <= 1'b0;
      repeat (40) @(posedge clock);
      k = 0;
      while (k < 12000 && absPosition_q !== expPos[13:0]) begin
        @(posedge clock);
        k = k + 1;
      end
      // Extra time shows any overshoot past the target.
      repeat (600) @(posedge clock);
      check({18'h0, absPosition_q}, expPos);
      regRd(`ADDR_POSITION, expPos);
      check((((netCount - oldNet) % n) + n) % n, (((expPos - oldPos) % n) + n) % n);
      if (expGap > 0) begin
        check(minGap, expGap);
      end
    end
  endtask

  initial begin
    #(40000 * 40);
    failures = failures + 1;
    wrap_up;
  end

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    sinSample = 12'h000;
    cosSample = 12'h000;
    sampleValid = 1'b0;
    markEnable = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    clearStats = 1'b0;
    failures = 0;
    num_checks = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    regRd(`ADDR_CTRL, 32'h0000_0002);
    regRd(8'h10, 32'h0000_0000);
    regWr(`ADDR_POSITION, 32'hFFFF_FFFF);
    regRd(`ADDR_CTRL, 32'h0000_0002);
    regWr(`ADDR_CTRL, 32'h0000_01AB);
    regRd(`ADDR_CTRL, 32'h0000_01AB);
    // 32 counts per turn, positive direction, no hysteresis.
    regWr(`ADDR_CTRL, 32'h0000_0008);
    move(12'h000, 12'h3E8, 0, 0, 32, 0);
    regRd(`ADDR_STATUS, 32'h0000_0000);
    check(reference_mark_out_q, 1);
    @(posedge clock);
    markEnable <= 1'b0;
    repeat (3) @(posedge clock);
    check(reference_mark_out_q, 0);
    markEnable <= 1'b1;
    // About 50.6 degrees sits mid-bin, clear of rounding in the arctangent.
    move(12'h3CF, 12'h320, 4, 0, 32, 470);
    move(12'h1E8, 12'h190, 4, 4, 32, 0);
    regWr(`ADDR_CTRL, 32'h0000_0108);
    move(12'h3CF, 12'h320, 27, 4, 32, 470);
    check(markCount, 1);
    // Decimal 40 counts, crossing zero again with the mark disabled.
    regWr(`ADDR_CTRL, 32'h0000_0014);
    markEnable <= 1'b0;
    move(12'h3CF, 12'h320, 5, 27, 40, 390);
    check(markCount, 0);
    // Widest band at 32 counts: about 56.9 degrees is past the count 5 edge, but the band holds the count at 4.
    regWr(`ADDR_CTRL, 32'h0000_00A8);
    move(12'h399, 12'h258, 4, 5, 32, 0);
    check(badSteps, 0);
    wrap_up;
  end
endmodule
